// ==== rtl/pdsb_pkg.sv ====
// Shared constants and types for the pre-driver slew, bias and bootstrap init block.
// Assumes a 25 MHz system clock and a 16-bit register word.
package pdsb_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ           = 25000000;
    localparam int INIT_TIME_MS     = 36;
    localparam int INIT_TIMER_CYCLES = (INIT_TIME_MS * CLK_HZ) / 1000;
    localparam int TMR_W            = 20;
    localparam int TMR_MSB_W        = 6;

    // ==========================================================
    // Geometry
    localparam int NUM_HS  = 5;
    localparam int NUM_LS  = 7;
    localparam int NUM_OUT = NUM_HS + NUM_LS;
    localparam int NUM_UC  = 4;

    // ==========================================================
    // Register offsets (word addresses on the serial register port)
    localparam logic [9:0] HS_RATE_OFS   = 10'h18e;
    localparam logic [9:0] LS_RATE_OFS   = 10'h18f;
    localparam logic [9:0] BIAS_OFS      = 10'h1a4;
    localparam logic [9:0] CHARGE_OFS    = 10'h1a5;

    // ==========================================================
    // Field positions and reset values
    localparam int LS7_FALL_POS   = 12;
    localparam int LS7_RISE_POS   = 14;
    localparam int HS_PU_POS      = 0;
    localparam int LS_PD_POS      = 5;
    localparam int HS2_SPU_POS    = 11;
    localparam int HS4_SPU_POS    = 12;
    localparam int CHG_UPPER_POS  = 5;
    localparam int CHG_TMR_POS    = 10;
    localparam logic [15:0] HS_RATE_RST = 16'h0000;
    localparam logic [15:0] LS_RATE_RST = 16'h0000;
    localparam logic [15:0] BIAS_RST    = 16'h0000;
    localparam logic [4:0]  CHARGED_RST = 5'h1f;
    localparam logic [9:0]  HS_RATE_MASK = 10'h3ff;
    localparam logic [12:0] BIAS_MASK    = 13'h1fff;

    // Source threshold codes forced during init (analog code values)
    localparam logic [2:0] THR_LOW_CODE  = 3'h0;
    localparam logic [2:0] THR_HIGH_CODE = 3'h1;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        PDSB_PRE  = 4'h1,
        PDSB_LOW  = 4'h2,
        PDSB_HIGH = 4'h4,
        PDSB_DONE = 4'h8
    } pdsb_init_e;

    typedef struct packed {
        logic              uv;
        logic [NUM_HS-1:0] src_below;
        logic [NUM_HS-1:0] bs_ready;
        logic [NUM_HS-1:0] clamp;
        logic              dbg;
    } pdsb_pins_s;

    typedef struct packed {
        logic [9:0]              hs_rate;
        logic [15:0]             ls_rate;
        logic [12:0]             bias;
        pdsb_init_e [NUM_HS-1:0] st;
        logic [TMR_W-1:0]        tmr;
        logic                    tmr_done;
        logic                    tmr_run;
        logic [NUM_HS-1:0]       upper;
        logic [NUM_HS-1:0]       charged;
        logic                    strap;
        logic [1:0]              strap_taken;
        pdsb_pins_s              sync1;
        pdsb_pins_s              sync2;
        logic [15:0]             rdata;
    } pdsb_state_s;

endpackage : pdsb_pkg

// ==== rtl/pdsb_top.sv ====
// Slew-rate and bias register bank with per-high-side bootstrap init sequencing.
// Assumes the serial register port and the microcore write port run on clk_in;
// comparator levels, the undervoltage flag and the debug strap arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Microcore slew writes land only on outputs it holds access to; serial always.
// - Seventh low-side driver has separate rise and fall rates; others share one.
// - High-side rate register: five 2-bit fields in bits 9:0, rest reserved, reset zero.
// - Low-side rate register: six fields, then seventh fall 13:12, rise 15:14.
// - Bias register: five pull-ups, six pull-downs, strong pull-ups for HS2, HS4.
// - Microcore bias writes land only on outputs it holds access to.
// - Serial read of bias returns effective bias after init overrides.
// - Each initializing high-side driver gets its own low-current-limit mode.
// - Source threshold forced low, later high, during init; programmed value afterwards.
// - All low-side bias forced on while any high-side driver initializes.
// - High-side bias forced off during that driver's own initialization.
// - External regulator enable forced to 0 during init if strap sampled 1.
// - After reset each init machine enters low-threshold state once undervoltage clears.
// - One global 36 ms timer starts when undervoltage clears.
// - At terminal count, still-initializing drivers go high-threshold and flag it.
// - Init ends on source below threshold with bootstrap ready or clamp.
// - Init also ends on coupled low-side active or high-side switched on.
// - Setting a driver's coupling-disable bit ends its initialization.
// - Coupled-active for HS1/HS2 is any mapped low-side on, or coupling disabled.
// - Each high-side charge status bit resets to 1 and reads 0 once charged.
module pdsb_top #(
    parameter int INIT_CYCLES = pdsb_pkg::INIT_TIMER_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        pin_reset_n_in,
    // Serial register port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [9:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    // Microcore write port
    input  wire logic        uc_wr_in,
    input  wire logic [1:0]  uc_id_in,
    input  wire logic [9:0]  uc_addr_in,
    input  wire logic [15:0] uc_wdata_in,
    input  wire logic [pdsb_pkg::NUM_UC*pdsb_pkg::NUM_OUT-1:0] output_access_rights_in,
    // Status from the analog side and the core
    input  wire logic        regulator_undervoltage_flag_in,
    input  wire logic        debug_strap_pin_in,
    input  wire logic [4:0]  src_below_thr_in,
    input  wire logic [4:0]  bs_ready_in,
    input  wire logic [4:0]  clamp_active_in,
    input  wire logic [4:0]  hs_on_in,
    input  wire logic [6:0]  ls_on_in,
    input  wire logic [13:0] coupling_map_in,
    input  wire logic [4:0]  coupling_disable_in,
    input  wire logic [4:2]  coupled_low_active_in,
    input  wire logic [14:0] src_thr_cfg_in,
    input  wire logic        vccp_ext_enable_cfg_in,
    // To the pre-drivers
    output logic      [9:0]  high_rate_out,
    output logic      [11:0] low_rate_out,
    output logic      [1:0]  seventh_low_rise_rate_out,
    output logic      [1:0]  seventh_low_fall_rate_out,
    output logic      [4:0]  high_bias_drive_out,
    output logic      [1:0]  high_strong_bias_drive_out,
    output logic      [5:0]  low_bias_drive_out,
    output logic      [4:0]  init_low_current_limit_out,
    output logic      [14:0] src_thr_out,
    output logic             vccp_ext_enable_out,
    output logic      [4:0]  capacitor_charge_status_out,
    output logic      [4:0]  upper_threshold_used_out
);

    // ==========================================================
    // Reset release
    logic [1:0]  rst_sync_r;
    logic        rst_n;

    always_ff @(posedge clk_in or negedge rst_n_in or negedge pin_reset_n_in)
    begin
        if (!rst_n_in || !pin_reset_n_in)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ==========================================================
    // Access masks: bit b of each register belongs to output map_x(b)
    pdsb_pkg::pdsb_state_s st_r;
    pdsb_pkg::pdsb_state_s st_nxt;
    logic [11:0] acc;
    logic [9:0]  hs_acc_mask;
    logic [15:0] ls_acc_mask;
    logic [12:0] bias_acc_mask;
    logic [4:0]  in_init;
    logic        any_init;
    logic [4:0]  coupled;
    logic [4:0]  init_end;
    logic [12:0] bias_eff;

    assign acc = output_access_rights_in[uc_id_in*pdsb_pkg::NUM_OUT +: pdsb_pkg::NUM_OUT];

    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_hs
            assign hs_acc_mask[2*g +: 2] = {2{acc[g]}};
            assign bias_acc_mask[pdsb_pkg::HS_PU_POS + g] = acc[g];
            assign in_init[g] = (st_r.st[g] == pdsb_pkg::PDSB_LOW)
                             || (st_r.st[g] == pdsb_pkg::PDSB_HIGH);
            // Forced threshold while initializing, programmed code otherwise
            assign src_thr_out[3*g +: 3] = !in_init[g] ? src_thr_cfg_in[3*g +: 3] :
                (st_r.st[g] == pdsb_pkg::PDSB_HIGH) ? pdsb_pkg::THR_HIGH_CODE
                                                     : pdsb_pkg::THR_LOW_CODE;
            // Charged source or any coupling reason ends init
            assign init_end[g] = (st_r.sync2.src_below[g]
                                  && (st_r.sync2.bs_ready[g] || st_r.sync2.clamp[g]))
                              || coupled[g] || hs_on_in[g];
        end
        for (g = 0; g < 6; g++)
        begin : g_ls
            assign ls_acc_mask[2*g +: 2] = {2{acc[5+g]}};
            assign bias_acc_mask[pdsb_pkg::LS_PD_POS + g] = acc[5+g];
        end
        for (g = 0; g < 2; g++)
        begin : g_cpl
            // Mapped low-side on, or coupling turned off
            assign coupled[g] = |(coupling_map_in[7*g +: 7] & ls_on_in)
                              || coupling_disable_in[g];
        end
    endgenerate
    assign ls_acc_mask[15:12] = {4{acc[11]}};
    assign bias_acc_mask[pdsb_pkg::HS2_SPU_POS] = acc[1];
    assign bias_acc_mask[pdsb_pkg::HS4_SPU_POS] = acc[3];
    assign coupled[4:2] = coupled_low_active_in | coupling_disable_in[4:2];
    assign any_init = |in_init;

    // ==========================================================
    // Effective bias after init overrides
    always_comb
    begin
        bias_eff = st_r.bias;
        bias_eff[pdsb_pkg::HS_PU_POS +: 5] = st_r.bias[pdsb_pkg::HS_PU_POS +: 5] & ~in_init;
        bias_eff[pdsb_pkg::HS2_SPU_POS] = st_r.bias[pdsb_pkg::HS2_SPU_POS] & ~in_init[1];
        bias_eff[pdsb_pkg::HS4_SPU_POS] = st_r.bias[pdsb_pkg::HS4_SPU_POS] & ~in_init[3];
        if (any_init)
            bias_eff[pdsb_pkg::LS_PD_POS +: 6] = 6'h3f;
    end

    localparam logic [pdsb_pkg::TMR_W-1:0] TMR_LAST = pdsb_pkg::TMR_W'(INIT_CYCLES - 1);
    logic [5:0] tmr_msb;
    // Timer shows 6'h3f once lapsed, its top bits while running
    assign tmr_msb = st_r.tmr_done ? 6'h3f
                   : st_r.tmr[pdsb_pkg::TMR_W-1 -: pdsb_pkg::TMR_MSB_W];

    // ==========================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = '{uv: regulator_undervoltage_flag_in, src_below: src_below_thr_in,
                         bs_ready: bs_ready_in, clamp: clamp_active_in,
                         dbg: debug_strap_pin_in};
        st_nxt.sync2 = st_r.sync1;

        // Strap is caught once, when the synchroniser holds the real pin level
        if (st_r.strap_taken != 2'h3)
            st_nxt.strap_taken = st_r.strap_taken + 2'h1;
        if (st_r.strap_taken == 2'h2)
            st_nxt.strap = st_r.sync2.dbg;

        // Microcore writes first, so a serial write in the same cycle wins
        if (uc_wr_in)
        begin
            if (uc_addr_in == pdsb_pkg::HS_RATE_OFS)
                st_nxt.hs_rate = (st_r.hs_rate & ~hs_acc_mask)
                               | (uc_wdata_in[9:0] & hs_acc_mask);
            if (uc_addr_in == pdsb_pkg::LS_RATE_OFS)
                st_nxt.ls_rate = (st_r.ls_rate & ~ls_acc_mask)
                               | (uc_wdata_in & ls_acc_mask);
            if (uc_addr_in == pdsb_pkg::BIAS_OFS)
                st_nxt.bias = (st_r.bias & ~bias_acc_mask)
                            | (uc_wdata_in[12:0] & bias_acc_mask);
        end
        if (reg_wr_in)
        begin
            if (reg_addr_in == pdsb_pkg::HS_RATE_OFS)
                st_nxt.hs_rate = reg_wdata_in[9:0] & pdsb_pkg::HS_RATE_MASK;
            if (reg_addr_in == pdsb_pkg::LS_RATE_OFS)
                st_nxt.ls_rate = reg_wdata_in;
            if (reg_addr_in == pdsb_pkg::BIAS_OFS)
                st_nxt.bias = reg_wdata_in[12:0] & pdsb_pkg::BIAS_MASK;
        end

        // Global timer: starts when the regulator is good, then free of it
        if (!st_r.sync2.uv)
            st_nxt.tmr_run = 1'b1;
        if (st_r.tmr_run && !st_r.tmr_done)
        begin
            if (st_r.tmr == TMR_LAST)
                st_nxt.tmr_done = 1'b1;
            else
                st_nxt.tmr = st_r.tmr + 1'b1;
        end

        for (int i = 0; i < 5; i++)
        begin
            case (st_r.st[i])
                pdsb_pkg::PDSB_PRE:
                    if (!st_r.sync2.uv)
                        st_nxt.st[i] = pdsb_pkg::PDSB_LOW;
                pdsb_pkg::PDSB_LOW:
                    if (init_end[i])
                    begin
                        st_nxt.st[i] = pdsb_pkg::PDSB_DONE;
                        st_nxt.charged[i] = 1'b0;
                    end
                    else if (st_r.tmr_done)
                    begin
                        st_nxt.st[i] = pdsb_pkg::PDSB_HIGH;
                        st_nxt.upper[i] = 1'b1;
                    end
                pdsb_pkg::PDSB_HIGH:
                    if (init_end[i])
                    begin
                        st_nxt.st[i] = pdsb_pkg::PDSB_DONE;
                        st_nxt.charged[i] = 1'b0;
                    end
                pdsb_pkg::PDSB_DONE:
                    st_nxt.st[i] = pdsb_pkg::PDSB_DONE;
                default:
                    st_nxt.st[i] = pdsb_pkg::PDSB_PRE;
            endcase
        end

        // Read data: bias reads back its effective value
        st_nxt.rdata = 16'h0000;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                pdsb_pkg::HS_RATE_OFS: st_nxt.rdata = {6'h00, st_r.hs_rate};
                pdsb_pkg::LS_RATE_OFS: st_nxt.rdata = st_r.ls_rate;
                pdsb_pkg::BIAS_OFS:    st_nxt.rdata = {3'h0, bias_eff};
                pdsb_pkg::CHARGE_OFS:  st_nxt.rdata = {tmr_msb, st_r.upper, st_r.charged};
                default:               st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r          <= '0;
            st_r.hs_rate  <= pdsb_pkg::HS_RATE_RST[9:0];
            st_r.ls_rate  <= pdsb_pkg::LS_RATE_RST;
            st_r.bias     <= pdsb_pkg::BIAS_RST[12:0];
            st_r.st       <= '{default: pdsb_pkg::PDSB_PRE};
            st_r.charged  <= pdsb_pkg::CHARGED_RST;
            st_r.sync1.uv <= 1'b1;
            st_r.sync2.uv <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_out = st_r.rdata;
    assign high_rate_out = st_r.hs_rate;
    assign low_rate_out  = st_r.ls_rate[11:0];
    assign seventh_low_fall_rate_out = st_r.ls_rate[pdsb_pkg::LS7_FALL_POS +: 2];
    assign seventh_low_rise_rate_out = st_r.ls_rate[pdsb_pkg::LS7_RISE_POS +: 2];
    assign high_bias_drive_out = bias_eff[pdsb_pkg::HS_PU_POS +: 5];
    assign high_strong_bias_drive_out = {bias_eff[pdsb_pkg::HS4_SPU_POS],
                                         bias_eff[pdsb_pkg::HS2_SPU_POS]};
    assign low_bias_drive_out = bias_eff[pdsb_pkg::LS_PD_POS +: 6];
    assign init_low_current_limit_out = in_init;
    // Strap of 1 keeps the internal regulator on until every driver is charged
    assign vccp_ext_enable_out = (any_init && st_r.strap) ? 1'b0 : vccp_ext_enable_cfg_in;
    assign capacitor_charge_status_out = st_r.charged;
    assign upper_threshold_used_out = st_r.upper;

endmodule : pdsb_top

`default_nettype wire

// ==== sim/pdsb_top_sva.sv ====
// Port-level assertions for pdsb_top.
// Bound to the design by the testbench; sees top ports only.
`timescale 1ns/100ps
`default_nettype none
module pdsb_top_sva #(
    parameter int INIT_CYCLES = 40
) (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        pin_reset_n_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [9:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        uc_wr_in,
    input wire logic [1:0]  uc_id_in,
    input wire logic [9:0]  uc_addr_in,
    input wire logic [47:0] output_access_rights_in,
    input wire logic [4:0]  hs_on_in,
    input wire logic [4:0]  coupling_disable_in,
    input wire logic [14:0] src_thr_cfg_in,
    input wire logic        vccp_ext_enable_cfg_in,
    input wire logic [9:0]  high_rate_out,
    input wire logic [1:0]  seventh_low_rise_rate_out,
    input wire logic [1:0]  seventh_low_fall_rate_out,
    input wire logic [4:0]  high_bias_drive_out,
    input wire logic [1:0]  high_strong_bias_drive_out,
    input wire logic [5:0]  low_bias_drive_out,
    input wire logic [4:0]  init_low_current_limit_out,
    input wire logic [14:0] src_thr_out,
    input wire logic        vccp_ext_enable_out,
    input wire logic [4:0]  capacitor_charge_status_out,
    input wire logic [4:0]  upper_threshold_used_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || !pin_reset_n_in);
    logic [4:0] ini;
    assign ini = init_low_current_limit_out;
    // ==========================================
    // Register bank
    AST_HS_WRITE: assert property (
        reg_wr_in && reg_addr_in == pdsb_pkg::HS_RATE_OFS
        |=> high_rate_out == $past(reg_wdata_in[9:0])) else $error("high rate not written");
    AST_LS7_SPLIT: assert property (
        reg_wr_in && reg_addr_in == pdsb_pkg::LS_RATE_OFS |=> {seventh_low_rise_rate_out,
        seventh_low_fall_rate_out} == $past(reg_wdata_in[15:12])) else $error("ls7 rates");
    AST_UC_REFUSED: assert property (
        uc_wr_in && !reg_wr_in && uc_addr_in == pdsb_pkg::HS_RATE_OFS
        && !output_access_rights_in[uc_id_in * 12] |=> $stable(high_rate_out[1:0]))
        else $error("microcore write without right landed");
    AST_BIAS_READ: assert property (
        reg_rd_in && reg_addr_in == pdsb_pkg::BIAS_OFS |=> reg_rdata_out == {3'h0,
        $past(high_strong_bias_drive_out), $past(low_bias_drive_out),
        $past(high_bias_drive_out)}) else $error("bias read not effective value");
    // ==========================================
    // Bootstrap init overrides
    AST_LOW_FORCED: assert property (
        |ini |-> low_bias_drive_out == 6'h3f) else $error("low bias not forced");
    AST_HIGH_MASKED: assert property (
        (high_bias_drive_out & ini) == 5'h0) else $error("high bias on during init");
    AST_VCCP: assert property (
        (vccp_ext_enable_out & ~vccp_ext_enable_cfg_in) == 1'b0
        && (|ini || vccp_ext_enable_out == vccp_ext_enable_cfg_in)) else $error("vccp");
    AST_THR_INIT: assert property (
        ini[0] |-> src_thr_out[2:0] == (upper_threshold_used_out[0] ?
        pdsb_pkg::THR_HIGH_CODE : pdsb_pkg::THR_LOW_CODE)) else $error("forced threshold");
    AST_THR_BACK: assert property (
        !ini[0] |-> src_thr_out[2:0] == src_thr_cfg_in[2:0]) else $error("threshold restore");
    AST_UPPER_RISE: assert property (
        $rose(upper_threshold_used_out[3]) |-> ini[3]
        && src_thr_out[11:9] == pdsb_pkg::THR_HIGH_CODE) else $error("upper flag");
    AST_CHARGE_END: assert property (
        $fell(capacitor_charge_status_out[0]) |-> !ini[0] && $past(ini[0]))
        else $error("charge flag without init end");
    AST_HS_ON_END: assert property (
        ini[2] && hs_on_in[2] |=> !ini[2]) else $error("switch-on did not end init");
    AST_DISABLE_END: assert property (
        ini[4] && coupling_disable_in[4] |=> !ini[4]) else $error("disable did not end init");
    COV_UPPER: cover property ($rose(|upper_threshold_used_out));
    COV_CHARGED: cover property ($fell(capacitor_charge_status_out[0]));
    COV_READ_INIT: cover property (reg_rd_in && reg_addr_in == pdsb_pkg::BIAS_OFS && |ini);
endmodule : pdsb_top_sva
`default_nettype wire

// ==== sim/pdsb_analog_model.sv ====
// Behavioural bootstrap comparators of the five high-side stages.
// A stage charges a few cycles into init unless the bench holds it off.
`timescale 1ns/100ps
`default_nettype none
module pdsb_analog_model (
    input  wire logic       clk_in,
    input  wire logic [4:0] init_in,
    input  wire logic [4:0] hold_in,
    input  wire logic [4:0] use_clamp_in,
    output logic      [4:0] src_below_out,
    output logic      [4:0] bs_ready_out,
    output logic      [4:0] clamp_out
);
    // ==========================================
    // Charge timing; levels drop again once init ends, as on silicon
    int cnt [5] = '{default: 0};
    always @(posedge clk_in)
        for (int i = 0; i < 5; i++)
            cnt[i] <= (init_in[i] && !hold_in[i]) ? cnt[i] + 1 : 0;
    always_comb
        for (int i = 0; i < 5; i++)
        begin
            src_below_out[i] = cnt[i] > 3;
            bs_ready_out[i]  = cnt[i] > 3 && !use_clamp_in[i];
            clamp_out[i]     = cnt[i] > 3 && use_clamp_in[i];
        end
endmodule : pdsb_analog_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for pdsb_top with a shortened init timer.
// Needs pdsb_pkg, pdsb_top, pdsb_top_sva and pdsb_analog_model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int INIT_N = 40;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, pin_reset_n_in = 1'b1;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, uc_wr_in = 1'b0;
    logic [9:0]  reg_addr_in = 10'h0, uc_addr_in = 10'h0, high_rate_out;
    logic [15:0] reg_wdata_in = 16'h0, uc_wdata_in = 16'h0, reg_rdata_out;
    logic [1:0]  uc_id_in = 2'h0, seventh_low_rise_rate_out, seventh_low_fall_rate_out;
    logic [47:0] output_access_rights_in = 48'h1000;
    logic        regulator_undervoltage_flag_in = 1'b1, debug_strap_pin_in = 1'b1;
    logic [4:0]  src_below_thr_in, bs_ready_in, clamp_active_in, hs_on_in = 5'h0;
    logic [6:0]  ls_on_in = 7'h0;
    logic [13:0] coupling_map_in = 14'h2000;
    logic [4:0]  coupling_disable_in = 5'h0, hold = 5'h1f, uclamp = 5'h08;
    logic [4:2]  coupled_low_active_in = 3'h0;
    logic [14:0] src_thr_cfg_in = 15'h5b6d, src_thr_out;
    logic        vccp_ext_enable_cfg_in = 1'b1, vccp_ext_enable_out;
    logic [11:0] low_rate_out;
    logic [4:0]  high_bias_drive_out, init_low_current_limit_out, capacitor_charge_status_out;
    logic [4:0]  upper_threshold_used_out;
    logic [1:0]  high_strong_bias_drive_out;
    logic [5:0]  low_bias_drive_out;
    logic [15:0] d;
    int          miscompares = 0, n_compared = 0;

    pdsb_top #(.INIT_CYCLES(INIT_N)) i_dut (.*);
    pdsb_analog_model i_analog (.clk_in(clk_in), .init_in(init_low_current_limit_out),
        .hold_in(hold), .use_clamp_in(uclamp), .src_below_out(src_below_thr_in),
        .bs_ready_out(bs_ready_in), .clamp_out(clamp_active_in));

    initial
        forever #20 clk_in = ~clk_in;

    // ==========================================
    // Shared tasks
    task automatic conclude;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic wr(input logic [9:0] a, input logic [15:0] v, input bit uc, input int id);
        tick(1);
        {reg_wr_in, uc_wr_in} = uc ? 2'b01 : 2'b10;
        {reg_addr_in, uc_addr_in, reg_wdata_in, uc_wdata_in} = {a, a, v, v};
        uc_id_in = id[1:0];
        tick(1);
        {reg_wr_in, uc_wr_in} = 2'b00;
    endtask : wr

    task automatic rd(input logic [9:0] a);
        tick(1);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        tick(1);
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
    endtask : rd

    task automatic wait_clear(input logic [4:0] m, input bit up = 1'b0);
        int k;
        for (k = 0; k < 200 && ((up ? ~upper_threshold_used_out
                                    : init_low_current_limit_out) & m) !== 5'h0; k++)
            tick(1);
        if (k == 200)
        begin
            miscompares++;
            conclude();
        end
    endtask : wait_clear

    // ==========================================
    // Scenarios
    task automatic t_regs;
        rd(pdsb_pkg::LS_RATE_OFS);
        chk("ls rate reset", d, 16'h0000);
        rd(pdsb_pkg::CHARGE_OFS);
        chk("charge reset", d, 16'h001f);
        wr(pdsb_pkg::HS_RATE_OFS, 16'hffff, 0, 0);
        chk("hs rate out", high_rate_out, 16'h03ff);
        rd(pdsb_pkg::HS_RATE_OFS);
        chk("hs rate read", d, 16'h03ff);
        wr(pdsb_pkg::LS_RATE_OFS, 16'he4c6, 0, 0);
        chk("ls rates", {seventh_low_rise_rate_out, seventh_low_fall_rate_out, low_rate_out},
            16'he4c6);
        wr(pdsb_pkg::BIAS_OFS, 16'hffff, 0, 0);
        rd(pdsb_pkg::BIAS_OFS);
        chk("bias read", d, 16'h1fff);
        rd(10'h100);
        chk("unmapped read", d, 16'h0000);
        wr(pdsb_pkg::HS_RATE_OFS, 16'h0000, 1, 0);
        chk("uc no right", high_rate_out, 16'h03ff);
        wr(pdsb_pkg::HS_RATE_OFS, 16'h0000, 1, 1);
        chk("uc with right", high_rate_out, 16'h03fc);
        wr(pdsb_pkg::BIAS_OFS, 16'h0000, 1, 1);
        rd(pdsb_pkg::BIAS_OFS);
        chk("uc bias", d, 16'h1ffe);
        // No two stages share a source node, so early pull-ups are allowed
        wr(pdsb_pkg::BIAS_OFS, 16'h181e, 0, 0);
        $display("test registers done");
    endtask : t_regs

    task automatic t_init;
        regulator_undervoltage_flag_in = 1'b0;
        tick(4);
        chk("all in init", init_low_current_limit_out, 16'h001f);
        chk("low_bias_drive forced", low_bias_drive_out, 16'h003f);
        chk("high_bias_drive masked", high_bias_drive_out, 16'h0000);
        chk("vccp forced", vccp_ext_enable_out, 16'h0000);
        chk("low thresholds", src_thr_out, 16'h0000);
        rd(pdsb_pkg::BIAS_OFS);
        chk("effective bias", d[10:0], 16'h07e0);
        hold = 5'h1e;
        wait_clear(5'h01);
        chk("hs1 charged", capacitor_charge_status_out, 16'h001e);
        chk("others still", init_low_current_limit_out, 16'h001e);
        chk("hs1 threshold", src_thr_out[2:0], 16'h0005);
        ls_on_in = 7'h40;
        wait_clear(5'h02);
        ls_on_in = 7'h00;
        chk("hs2 coupled", capacitor_charge_status_out, 16'h001c);
        hs_on_in = 5'h04;
        tick(1);
        hs_on_in = 5'h00;
        chk("hs3 switched on", init_low_current_limit_out, 16'h0018);
        chk("no lapse yet", upper_threshold_used_out, 16'h0000);
        wait_clear(5'h18, 1'b1);
        chk("upper flags", upper_threshold_used_out, 16'h0018);
        chk("high thresholds", src_thr_out[14:9], {10'h0, 3'h1, 3'h1});
        rd(pdsb_pkg::CHARGE_OFS);
        chk("timer lapsed", d, 16'hff18);
        hold = 5'h10;
        wait_clear(5'h08);
        coupling_disable_in = 5'h10;
        wait_clear(5'h10);
        chk("all charged", capacitor_charge_status_out, 16'h0000);
        chk("low_bias_drive back", low_bias_drive_out, 16'h0000);
        chk("high_bias_drive back", high_bias_drive_out, 16'h001e);
        chk("vccp back", vccp_ext_enable_out, 16'h0001);
        $display("test init done");
    endtask : t_init

    task automatic t_again;
        pin_reset_n_in = 1'b0;
        tick(2);
        chk("upper cleared", upper_threshold_used_out, 16'h0000);
        chk("charge set", capacitor_charge_status_out, 16'h001f);
        chk("init idle", init_low_current_limit_out, 16'h0000);
        pin_reset_n_in = 1'b1;
        tick(3);
        rd(pdsb_pkg::HS_RATE_OFS);
        chk("rate cleared", d, 16'h0000);
        $display("test second reset done");
    endtask : t_again

    initial
    begin
        repeat (16) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        tick(3);
        t_regs();
        t_init();
        t_again();
        conclude();
    end
endmodule : testbench

bind pdsb_top pdsb_top_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (.*);
`default_nettype wire
